// File: bench/irq_set_enable_bank_four_tb_top.sv
// Testbench: register-level checks of the fourth interrupt enable bank
`timescale 1ns/1ns
`default_nettype none
module irq_set_enable_bank_four_tb_top
    import irq_enable_pkg::*;
;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic [31:0] rdata_out;
    logic [31:0] irq_enable_out;
    int fail_count = 0;
    int comparisons = 0;
    irq_set_enable_bank_four i_dut (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
        .irq_enable_out(irq_enable_out));
    always #10 clock_in = ~clock_in;
    // ==========================================================
    // Bus tasks: each signal is assigned once per call, so calls may follow back to back
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        write_in <= w;
        read_in <= r;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
    endtask : access
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        access(1'b1, 1'b0, a, d);
        #1 chk(irq_enable_out, exp);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, 1'b1, a, 32'h0000_0000);
        #1 chk(rdata_out, exp);
    endtask : rd
    task automatic test_done();
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        #1 chk(irq_enable_out, ENABLE_RESET);
        rd(SET_BANK_OFFSET, 32'h0000_0000);
        for (int i = 0; i < 32; i++)
        begin
            wr(SET_BANK_OFFSET, 32'h0000_0001 << i, (32'h0000_0001 << i) & IMPLEMENTED_MASK);
            rd(SET_BANK_OFFSET, (32'h0000_0001 << i) & IMPLEMENTED_MASK);
            wr(CLEAR_BANK_OFFSET, 32'h0000_0001 << i, 32'h0000_0000);
        end
        wr(SET_BANK_OFFSET, 32'hFFFF_FFFF, 32'hFFFF_FFF9);
        wr(SET_BANK_OFFSET, 32'h0000_0000, 32'hFFFF_FFF9);
        wr(CLEAR_BANK_OFFSET, 32'h0000_0000, 32'hFFFF_FFF9);
        // Unmapped offset must neither clear nor read back the state
        wr(8'h08, 32'hFFFF_FFFF, 32'hFFFF_FFF9);
        rd(8'h08, 32'h0000_0000);
        rd(CLEAR_BANK_OFFSET, 32'hFFFF_FFF9);
        wr(CLEAR_BANK_OFFSET, 32'h8000_0001, 32'h7FFF_FFF8);
        rd(SET_BANK_OFFSET, 32'h7FFF_FFF8);
        access(1'b0, 1'b0, 8'h00, 32'h0000_0000);
        #1 chk(rdata_out, READ_ZERO);
        // Reset in mid-run wins over a read in the same cycle
        reset_in <= 1'b1;
        access(1'b0, 1'b1, SET_BANK_OFFSET, 32'h0000_0000);
        reset_in <= 1'b0;
        #1 chk(irq_enable_out, ENABLE_RESET);
        chk(rdata_out, READ_ZERO);
        wr(SET_BANK_OFFSET, 32'h0000_0008, 32'h0000_0008);
        rd(CLEAR_BANK_OFFSET, 32'h0000_0008);
        test_done();
    end
    // Generous bound: the sequence needs about one hundred and twelve cycles
    initial
    begin
        repeat (2000) @(posedge clock_in);
        fail_count++;
        test_done();
    end
endmodule : irq_set_enable_bank_four_tb_top
`default_nettype wire

// File: hw/irq_enable_bits_if.sv
// Interface: carries set and clear requests and the enable state between modules
`timescale 1ns/1ns
`default_nettype none
interface irq_enable_bits_if;
    logic [31:0] set_bits;
    logic [31:0] clear_bits;
    logic [31:0] enable_state;
    modport ctrl (output set_bits, output clear_bits, input enable_state);
    modport store (input set_bits, input clear_bits, output enable_state);
endinterface : irq_enable_bits_if
`default_nettype wire

// File: hw/irq_enable_pkg.sv
// Package: register map and field layout of the fourth interrupt enable bank
`default_nettype none
package irq_enable_pkg;
    // ==========================================================
    // Register offsets, byte addresses
    localparam logic [7:0] SET_BANK_OFFSET = 8'h00;
    localparam logic [7:0] CLEAR_BANK_OFFSET = 8'h04;
    // ==========================================================
    // Field layout
    localparam int REG_WIDTH = 32;
    localparam int FIRST_IRQ_NUMBER = 96;
    localparam int UPPER_FIELD_LSB = 3;
    localparam int LOWER_FIELD_BIT = 0;
    // Implemented positions: bits 31..3 and bit 0
    localparam logic [31:0] IMPLEMENTED_MASK = 32'hFFFF_FFF9;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : irq_enable_pkg
`default_nettype wire

// File: hw/irq_enable_store.sv
// Module: the shared enable state flip-flops
`timescale 1ns/1ns
`default_nettype none
module irq_enable_store
    import irq_enable_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    irq_enable_bits_if.store bits
);
    logic [31:0] enable_reg;
    logic [31:0] enable_next;

    // ==========================================================
    // State update
    always_comb
    begin
        // Set wins over clear if both land in one cycle
        enable_next = (enable_reg & ~bits.clear_bits) | bits.set_bits;
        enable_next = enable_next & IMPLEMENTED_MASK;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            enable_reg <= ENABLE_RESET;
        else
            enable_reg <= enable_next;
    end

    assign bits.enable_state = enable_reg;

    AST_UNIMPL_ZERO: assert property (@(posedge clock_in) disable iff (reset_in)
        (enable_reg & ~IMPLEMENTED_MASK) == 32'h0000_0000)
        else $error("Unimplemented enable bit set");
endmodule : irq_enable_store
`default_nettype wire

// File: hw/irq_set_enable_bank_four.sv
// Module: register front end of the fourth set-enable and clear-enable bank
`timescale 1ns/1ns
`default_nettype none
module irq_set_enable_bank_four
    import irq_enable_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] rdata_out,
    output logic [31:0] irq_enable_out
);
    irq_enable_bits_if bits ();
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] write_bits;
    logic set_addr;
    logic clear_addr;
    logic set_hit;
    logic clear_hit;
    logic read_hit;

    // ==========================================================
    // Address decode and write strobes
    // Both offsets are decoded once and shared by the write and read paths
    assign set_addr = (addr_in == SET_BANK_OFFSET);
    assign clear_addr = (addr_in == CLEAR_BANK_OFFSET);
    assign set_hit = write_in && set_addr;
    assign clear_hit = write_in && clear_addr;
    assign read_hit = read_in && (set_addr || clear_addr);
    // Only ones in implemented positions act; zeros and bits 2..1 are ignored
    assign write_bits = wdata_in & IMPLEMENTED_MASK;
    assign bits.set_bits = set_hit ? write_bits : 32'h0000_0000;
    assign bits.clear_bits = clear_hit ? write_bits : 32'h0000_0000;

    // One copy of the state serves both offsets, so set and clear can never disagree
    irq_enable_store u_store (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .bits(bits)
    );

    // ==========================================================
    // Read path: both offsets show the same state, unmapped reads zero
    // Chosen before the flop, so read data stand for exactly one cycle
    always_comb
    begin
        if (read_hit)
            rdata_next = bits.enable_state;
        else
            rdata_next = READ_ZERO;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            rdata_reg <= READ_ZERO;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata_out = rdata_reg;
    // Bit n of the output is interrupt FIRST_IRQ_NUMBER + n
    assign irq_enable_out = bits.enable_state;

    // ==========================================================
    // Checks on writes
    AST_SET_ENABLES: assert property (@(posedge clock_in) disable iff (reset_in)
        set_hit
        |=> ((irq_enable_out & $past(wdata_in) & IMPLEMENTED_MASK) == ($past(wdata_in) & IMPLEMENTED_MASK)))
        else $error("Set write did not enable");

    AST_ZERO_KEEPS: assert property (@(posedge clock_in) disable iff (reset_in)
        set_hit
        |=> ((irq_enable_out & ~$past(wdata_in)) == ($past(irq_enable_out) & ~$past(wdata_in))))
        else $error("Zero write changed enable");

    AST_CLEAR_DISABLES: assert property (@(posedge clock_in) disable iff (reset_in)
        clear_hit
        |=> ((irq_enable_out & $past(wdata_in)) == 32'h0000_0000))
        else $error("Clear write did not disable");

    AST_CLEAR_ZERO_KEEPS: assert property (@(posedge clock_in) disable iff (reset_in)
        clear_hit
        |=> ((irq_enable_out & ~$past(wdata_in)) == ($past(irq_enable_out) & ~$past(wdata_in))))
        else $error("Clear zero write changed enable");

    AST_SET_NEVER_CLEARS: assert property (@(posedge clock_in) disable iff (reset_in)
        set_hit
        |=> (($past(irq_enable_out) & ~irq_enable_out) == 32'h0000_0000))
        else $error("Set write disabled an interrupt");

    AST_CLEAR_NEVER_SETS: assert property (@(posedge clock_in) disable iff (reset_in)
        clear_hit
        |=> ((~$past(irq_enable_out) & irq_enable_out) == 32'h0000_0000))
        else $error("Clear write enabled an interrupt");

    AST_OTHER_WRITE_KEEPS: assert property (@(posedge clock_in) disable iff (reset_in)
        (write_in && !set_addr && !clear_addr)
        |=> $stable(irq_enable_out))
        else $error("Write to another offset changed enable");

    AST_NO_WRITE_STABLE: assert property (@(posedge clock_in) disable iff (reset_in)
        !write_in
        |=> $stable(irq_enable_out))
        else $error("Enable changed without write");

    // ==========================================================
    // Checks on reads
    AST_READ_STATE: assert property (@(posedge clock_in) disable iff (reset_in)
        (read_in && set_addr)
        |=> (rdata_out == $past(irq_enable_out)))
        else $error("Read data wrong");

    AST_READ_CLEAR_STATE: assert property (@(posedge clock_in) disable iff (reset_in)
        (read_in && clear_addr)
        |=> (rdata_out == $past(irq_enable_out)))
        else $error("Read at clear offset wrong");

    AST_READ_OTHER_ZERO: assert property (@(posedge clock_in) disable iff (reset_in)
        (read_in && !set_addr && !clear_addr)
        |=> (rdata_out == READ_ZERO))
        else $error("Read at another offset not zero");

    AST_IDLE_READ_ZERO: assert property (@(posedge clock_in) disable iff (reset_in)
        !read_in
        |=> (rdata_out == READ_ZERO))
        else $error("Read data held past its cycle");

    // ==========================================================
    // Checks on reset and reserved positions
    AST_RESET_ZERO: assert property (@(posedge clock_in)
        reset_in
        |=> (irq_enable_out == ENABLE_RESET))
        else $error("Enable not zero after reset");

    AST_RESET_READ_ZERO: assert property (@(posedge clock_in)
        reset_in
        |=> (rdata_out == READ_ZERO))
        else $error("Read data not zero after reset");

    AST_MAP_BITS: assert property (@(posedge clock_in) disable iff (reset_in)
        irq_enable_out[2:1] == 2'b00)
        else $error("Unmapped bit enabled");

    // ==========================================================
    // Internal strobes: requests reach the store masked, one kind at a time
    AST_SET_CLEAR_EXCLUSIVE: assert property (@(posedge clock_in) disable iff (reset_in)
        !((bits.set_bits != 32'h0000_0000) && (bits.clear_bits != 32'h0000_0000)))
        else $error("Set and clear requests together");

    AST_SET_BITS_MASKED: assert property (@(posedge clock_in) disable iff (reset_in)
        ((bits.set_bits & ~IMPLEMENTED_MASK) == 32'h0000_0000))
        else $error("Set request on a reserved bit");

    AST_CLEAR_BITS_MASKED: assert property (@(posedge clock_in) disable iff (reset_in)
        ((bits.clear_bits & ~IMPLEMENTED_MASK) == 32'h0000_0000))
        else $error("Clear request on a reserved bit");

    AST_SET_BITS_IDLE: assert property (@(posedge clock_in) disable iff (reset_in)
        !set_hit
        |-> (bits.set_bits == 32'h0000_0000))
        else $error("Set request without a set write");

    AST_CLEAR_BITS_IDLE: assert property (@(posedge clock_in) disable iff (reset_in)
        !clear_hit
        |-> (bits.clear_bits == 32'h0000_0000))
        else $error("Clear request without a clear write");

    AST_SET_BITS_FOLLOW: assert property (@(posedge clock_in) disable iff (reset_in)
        set_hit
        |-> (bits.set_bits == (wdata_in & IMPLEMENTED_MASK)))
        else $error("Set request lost a written one");

    AST_CLEAR_BITS_FOLLOW: assert property (@(posedge clock_in) disable iff (reset_in)
        clear_hit
        |-> (bits.clear_bits == (wdata_in & IMPLEMENTED_MASK)))
        else $error("Clear request lost a written one");

    // ==========================================================
    // Per-bit checks: a fault in one position cannot hide behind the others
    for (genvar n = 0; n < REG_WIDTH; n++)
    begin : g_bit_check
        if (IMPLEMENTED_MASK[n])
        begin : g_mapped
            AST_BIT_SET: assert property (@(posedge clock_in) disable iff (reset_in)
                (set_hit && wdata_in[n])
                |=> irq_enable_out[n])
                else $error("Mapped bit not enabled by a set write");

            AST_BIT_CLEAR: assert property (@(posedge clock_in) disable iff (reset_in)
                (clear_hit && wdata_in[n])
                |=> !irq_enable_out[n])
                else $error("Mapped bit not disabled by a clear write");

            AST_BIT_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
                !((set_hit || clear_hit) && wdata_in[n])
                |=> $stable(irq_enable_out[n]))
                else $error("Mapped bit changed with no one written to it");

            AST_BIT_READ: assert property (@(posedge clock_in) disable iff (reset_in)
                read_hit
                |=> (rdata_out[n] == $past(irq_enable_out[n])))
                else $error("Mapped bit read back wrong");
        end
        else
        begin : g_reserved
            AST_BIT_RESERVED: assert property (@(posedge clock_in) disable iff (reset_in)
                !irq_enable_out[n])
                else $error("Reserved bit enabled");

            AST_BIT_RESERVED_READ: assert property (@(posedge clock_in) disable iff (reset_in)
                read_in
                |=> !rdata_out[n])
                else $error("Reserved bit read as one");
        end
    end
endmodule : irq_set_enable_bank_four
`default_nettype wire
